// ===== iosq_map.svh
/*
 * constants of the i/o pulse sequencer: register offsets, field positions,
 * reset values and timing counts.
 * assumes a 50 ns clock; included by its bare name, definitions only.
 */
`ifndef IOSQ_MAP_SVH
`define IOSQ_MAP_SVH

////////////////////////////////////////////////////////////////////////////
`define IOSQ_CLK_PERIOD_NS   50
`define IOSQ_SEP_MIN_NS      200
`define IOSQ_GAP_NS          100
`define IOSQ_WIDTH_MIN_NS    600
`define IOSQ_STB_NS          100
`define IOSQ_RESTART_DELAY_NS         275
`define IOSQ_GUARD_NS        200
// least times round up to whole clock cycles
`define IOSQ_NS2CYC(ns) (((ns) + `IOSQ_CLK_PERIOD_NS - 1) / `IOSQ_CLK_PERIOD_NS)
`define IOSQ_SEP_MIN_CYC     7'(`IOSQ_NS2CYC(`IOSQ_SEP_MIN_NS))
`define IOSQ_GAP_CYC         7'(`IOSQ_NS2CYC(`IOSQ_GAP_NS))
`define IOSQ_WIDTH_MIN_CYC   7'(`IOSQ_NS2CYC(`IOSQ_WIDTH_MIN_NS))
`define IOSQ_STB_CYC         7'(`IOSQ_NS2CYC(`IOSQ_STB_NS))
`define IOSQ_RESTART_DELAY_CYC        7'(`IOSQ_NS2CYC(`IOSQ_RESTART_DELAY_NS))
`define IOSQ_GUARD_CYC       7'(`IOSQ_NS2CYC(`IOSQ_GUARD_NS))
`define IOSQ_MULT_MIN        3'h1
`define IOSQ_MULT_MAX        3'h5

////////////////////////////////////////////////////////////////////////////
`define IOSQ_ADR_W           4
`define IOSQ_REG_CTRL        4'h0
`define IOSQ_REG_STAT        4'h4
`define IOSQ_CTRL_SEP_LSB    0
`define IOSQ_CTRL_WID_LSB    4
`define IOSQ_MULT_RST        3'h1
`define IOSQ_STAT_PEND_LSB   0
`define IOSQ_STAT_DONE_BIT   3
`define IOSQ_STAT_HOLD_BIT   4
`define IOSQ_STAT_WIN_BIT    5
`define IOSQ_STAT_BUSY_BIT   6

`endif

// ===== iosq_pkg.sv
/*
 * types of the i/o pulse sequencer: sequence states and signal carriers.
 * assumes iosq_map.svh for the numbers.
 */
package iosq_pkg;

  typedef enum logic [2:0] {
    ST_IDLE, ST_SEP, ST_GAP, ST_WIDTH, ST_STB, ST_GUARD, ST_RESTART_DELAY, ST_FINAL
  } iosq_state_t;

  typedef struct packed {
    logic w4;
    logic w2;
    logic w1;
  } iosq_cmd_t;

  typedef struct packed {
    logic one;
    logic two;
    logic three;
  } iosq_tp_t;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } iosq_wb_req_t;

endpackage

// ===== iosq_timer.sv
/*
 * down counter that times one interval of the pulse sequence.
 * assumes a synchronous load; o_last marks the final cycle of the interval.
 */
`timescale 1ns/1ps

module iosq_timer (
  input  wire logic       i_clk,
  input  wire logic       i_rst_n,
  input  wire logic       i_load,
  input  wire logic [6:0] i_cycles,
  output logic            o_last
);

  logic [6:0] cnt_ff;
  logic [6:0] nxt_cnt;

  assign nxt_cnt = i_load ? i_cycles :
                   (cnt_ff != 7'h0) ? cnt_ff - 7'h1 : 7'h0;
  assign o_last  = (cnt_ff == 7'h1);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      cnt_ff <= 7'h0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ===== iosq_wb_slave.sv
/*
 * classic wishbone slave with the control and status words.
 * assumes one master; every access, mapped or not, is acknowledged.
 */
`timescale 1ns/1ps
`include "iosq_map.svh"

module iosq_wb_slave (
  input  wire logic                  i_clk,
  input  wire logic                  i_rst_n,
  input  wire iosq_pkg::iosq_wb_req_t i_req,
  input  wire logic [6:0]            i_status,
  output logic                       o_ack,
  output logic [31:0]                o_rdata,
  output logic [2:0]                 o_sep_mult,
  output logic [2:0]                 o_width_mult
);

  logic        ack_ff;
  logic [31:0] rdata_ff;
  logic [2:0]  sep_ff;
  logic [2:0]  width_ff;
  logic        req;
  logic        wr_ctrl;
  logic [31:0] rd_word;

  // values outside 1..5 are pulled into range so readback is truthful
  function automatic logic [2:0] clamp(input logic [2:0] m);
    clamp = (m < `IOSQ_MULT_MIN) ? `IOSQ_MULT_MIN :
            (m > `IOSQ_MULT_MAX) ? `IOSQ_MULT_MAX : m;
  endfunction

  assign req     = i_req.cyc & i_req.stb;
  assign wr_ctrl = req & ack_ff & i_req.we & i_req.sel[0] &
                   (i_req.adr == `IOSQ_REG_CTRL);
  assign rd_word = (i_req.adr == `IOSQ_REG_CTRL) ?
                   {25'h0, width_ff, 1'b0, sep_ff} :
                   (i_req.adr == `IOSQ_REG_STAT) ? {25'h0, i_status} :
                   32'h0;

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0;
      sep_ff   <= `IOSQ_MULT_RST;
      width_ff <= `IOSQ_MULT_RST;
    end else begin
      ack_ff   <= req & ~ack_ff;
      rdata_ff <= rd_word;
      if (wr_ctrl) begin
        sep_ff   <= clamp(i_req.dat[`IOSQ_CTRL_SEP_LSB +: 3]);
        width_ff <= clamp(i_req.dat[`IOSQ_CTRL_WID_LSB +: 3]);
      end
    end
  end

  assign o_ack        = ack_ff;
  assign o_rdata      = rdata_ff;
  assign o_sep_mult   = sep_ff;
  assign o_width_mult = width_ff;

endmodule

// ===== iosq_top.sv
/*
 * i/o pulse sequencer: turns the three low instruction bits into ordered
 * command pulses, holds processor timing while they run, strobes the bus
 * at the end of each pulse and once more to resume the processor.
 * assumes processor time pulses and instruction bits synchronous to i_clk,
 * and a classic wishbone master for the interval settings.
 */
// Design decisions made here: the address map and the Wishbone slave port.
// Contract
// - instruction bits 9, 10, 11 map to command pulses of weight 4, 2, 1.
// - at time pulse two, set a pending flag for each set bit.
// - clear all pending flags at every time pulse one.
// - a command pulse is the window gated by its flag; flag clears at end.
// - several pending: least significant bit first, one per window.
// - a single pending flag pulses at the first window.
// - done is low while any flag is set, high after last pulse ends.
// - external transfer and not done asserts the timing-hold request.
// - time pulse three starts sequencing while processor waits.
// - each pulse: separation, fixed gap, then width interval.
// - window ends with the strobe interval, 100 ns longer than width.
// - separation at least 200 ns, width at least 600 ns, both adjustable.
// - separation and width adjustable up to five times minimum.
// - a bus strobe ends every command pulse.
// - after each pulse restart the interval chain while flags remain.
// - once done, no further width interval starts.
// - on done, wait 275 ns, then one more strobe interval.
// - the final strobe ends the exchange and releases the timing hold.
// - a guard interval blanks the done glitch at the end of the window.
// - bits 03 to 08 go out true and complemented for selection.
// - all 12 buffered instruction bits go to the peripheral.
`timescale 1ns/1ps
`include "iosq_map.svh"

module iosq_top (
  input  wire logic                   i_clk,
  input  wire logic                   i_nrst,
  input  wire iosq_pkg::iosq_wb_req_t i_wb_req,
  output logic                        o_wb_ack,
  output logic [31:0]                 o_wb_dat,
  input  wire logic [11:0]            i_instr_bits,
  input  wire logic                   i_io_instruction,
  input  wire logic                   i_internal_io,
  input  wire iosq_pkg::iosq_tp_t     i_time_pulse,
  output iosq_pkg::iosq_cmd_t         o_cmd_pulse,
  output logic [11:0]                 o_buffered_instr_bits,
  output logic [5:0]                  o_sel_bits_n,
  output logic                        o_bus_strobe,
  output logic                        o_timing_hold,
  output logic                        o_done
);

  ////////////////////////////////////////////////////////////////////////
  // reset release

  logic rst_meta_ff;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rst_meta_ff <= 1'b0;
      rst_n       <= 1'b0;
    end else begin
      rst_meta_ff <= 1'b1;
      rst_n       <= rst_meta_ff;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // declarations

  iosq_pkg::iosq_state_t state_ff;
  iosq_pkg::iosq_state_t nxt_state;
  iosq_pkg::iosq_cmd_t   cmd_ff;
  iosq_pkg::iosq_cmd_t   nxt_cmd;
  logic [2:0]            pending_ff;
  logic [2:0]            nxt_pending;
  logic [2:0]            instr_low;
  logic [2:0]            sel_low;
  logic [2:0]            pend_left;
  logic                  window_ff;
  logic                  nxt_window;
  logic                  strobe_ff;
  logic                  nxt_strobe;
  logic                  hold_ff;
  logic                  nxt_hold;
  logic                  done_ff;
  logic [11:0]           bufbits_ff;
  logic [5:0]            selbits_n_ff;
  logic                  tmr_load;
  logic [6:0]            tmr_cycles;
  logic                  tmr_last;
  logic [2:0]            sep_mult;
  logic [2:0]            width_mult;
  logic [6:0]            sep_cyc;
  logic [6:0]            width_cyc;
  logic                  stb_end;
  logic                  final_end;
  logic                  width_start;
  logic                  hold_req;
  logic                  busy;
  logic [6:0]            status;

  ////////////////////////////////////////////////////////////////////////
  // helpers

  // one-hot of the lowest set bit; bit 0 carries the weight-1 flag
  function automatic logic [2:0] lowest(input logic [2:0] v);
    lowest = v & (~v + 3'h1);
  endfunction

  function automatic logic [6:0] scale(input logic [6:0] base,
                                       input logic [2:0] mult);
    scale = 7'(base * mult);
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // registers and interval timer

  assign status = {busy, window_ff, hold_ff, done_ff, pending_ff};

  iosq_wb_slave u_wb (
    .i_clk        (i_clk),
    .i_rst_n      (rst_n),
    .i_req        (i_wb_req),
    .i_status     (status),
    .o_ack        (o_wb_ack),
    .o_rdata      (o_wb_dat),
    .o_sep_mult   (sep_mult),
    .o_width_mult (width_mult)
  );

  iosq_timer u_tmr (
    .i_clk    (i_clk),
    .i_rst_n  (rst_n),
    .i_load   (tmr_load),
    .i_cycles (tmr_cycles),
    .o_last   (tmr_last)
  );

  // multiplier register holds 1..5, so 5x minimum is the ceiling
  assign sep_cyc   = scale(`IOSQ_SEP_MIN_CYC, sep_mult);
  assign width_cyc = scale(`IOSQ_WIDTH_MIN_CYC,
                           width_mult);

  ////////////////////////////////////////////////////////////////////////
  // pending flags

  // bit numbering: index 0 is the most significant instruction bit
  assign instr_low = {i_instr_bits[9], i_instr_bits[10],
                      i_instr_bits[11]};
  assign sel_low   = lowest(pending_ff);
  assign pend_left = pending_ff & ~sel_low;
  assign stb_end   = (state_ff == iosq_pkg::ST_STB) & tmr_last;
  assign final_end = (state_ff == iosq_pkg::ST_FINAL) & tmr_last;

  // the flag of the pulse just issued drops as its window closes; a set at
  // time pulse two wins over that clear so no new request is lost
  assign nxt_pending = (i_time_pulse.one ? 3'h0 :
                        stb_end          ? pend_left :
                        pending_ff) |
                       ((i_time_pulse.two & ~i_time_pulse.one) ?
                        instr_low : 3'h0);

  ////////////////////////////////////////////////////////////////////////
  // sequence control

  assign hold_req    = i_io_instruction & ~i_internal_io & ~done_ff;
  assign busy        = (state_ff != iosq_pkg::ST_IDLE);
  assign width_start = (state_ff == iosq_pkg::ST_GAP) & tmr_last &
                       (pending_ff != 3'h0);

  always_comb begin
    nxt_state  = state_ff;
    tmr_load   = 1'b0;
    tmr_cycles = 7'h0;
    unique case (state_ff)
      iosq_pkg::ST_IDLE: begin
        if (hold_ff && i_time_pulse.three) begin
          nxt_state  = iosq_pkg::ST_SEP;
          tmr_load   = 1'b1;
          tmr_cycles = sep_cyc;
        end
      end
      iosq_pkg::ST_SEP: begin
        if (tmr_last) begin
          nxt_state  = iosq_pkg::ST_GAP;
          tmr_load   = 1'b1;
          tmr_cycles = `IOSQ_GAP_CYC;
        end
      end
      iosq_pkg::ST_GAP: begin
        if (width_start) begin
          nxt_state  = iosq_pkg::ST_WIDTH;
          tmr_load   = 1'b1;
          tmr_cycles = width_cyc;
        end else if (tmr_last) begin
          nxt_state  = iosq_pkg::ST_GUARD;
          tmr_load   = 1'b1;
          tmr_cycles = `IOSQ_GUARD_CYC;
        end
      end
      iosq_pkg::ST_WIDTH: begin
        if (tmr_last) begin
          nxt_state  = iosq_pkg::ST_STB;
          tmr_load   = 1'b1;
          tmr_cycles = `IOSQ_STB_CYC;
        end
      end
      iosq_pkg::ST_STB: begin
        if (tmr_last && pend_left != 3'h0) begin
          nxt_state  = iosq_pkg::ST_SEP;
          tmr_load   = 1'b1;
          tmr_cycles = sep_cyc;
        end else if (tmr_last) begin
          nxt_state  = iosq_pkg::ST_GUARD;
          tmr_load   = 1'b1;
          tmr_cycles = `IOSQ_GUARD_CYC;
        end
      end
      iosq_pkg::ST_GUARD: begin
        // done is only believed once the guard has run out
        if (tmr_last && done_ff) begin
          nxt_state  = iosq_pkg::ST_RESTART_DELAY;
          tmr_load   = 1'b1;
          tmr_cycles = `IOSQ_RESTART_DELAY_CYC;
        end else if (tmr_last) begin
          nxt_state  = iosq_pkg::ST_SEP;
          tmr_load   = 1'b1;
          tmr_cycles = sep_cyc;
        end
      end
      iosq_pkg::ST_RESTART_DELAY: begin
        if (tmr_last) begin
          nxt_state  = iosq_pkg::ST_FINAL;
          tmr_load   = 1'b1;
          tmr_cycles = `IOSQ_STB_CYC;
        end
      end
      iosq_pkg::ST_FINAL: begin
        if (tmr_last) begin
          nxt_state = iosq_pkg::ST_IDLE;
        end
      end
    endcase
  end

  ////////////////////////////////////////////////////////////////////////
  // outputs

  // window spans width and strobe, so it outlasts width by the strobe
  assign nxt_window = width_start |
                      (window_ff & ~stb_end);
  assign nxt_cmd    = {3{nxt_window}} & sel_low;
  assign nxt_strobe = (nxt_state == iosq_pkg::ST_STB) |
                      (nxt_state == iosq_pkg::ST_FINAL);
  // request wins; done is high at the final strobe, so no re-request
  assign nxt_hold   = hold_req | (hold_ff & ~final_end);

  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_ff     <= iosq_pkg::ST_IDLE;
      pending_ff   <= 3'h0;
      window_ff    <= 1'b0;
      cmd_ff       <= 3'h0;
      strobe_ff    <= 1'b0;
      hold_ff      <= 1'b0;
      done_ff      <= 1'b1;
      bufbits_ff   <= 12'h000;
      selbits_n_ff <= 6'h3f;
    end else begin
      state_ff     <= nxt_state;
      pending_ff   <= nxt_pending;
      window_ff    <= nxt_window;
      cmd_ff       <= nxt_cmd;
      strobe_ff    <= nxt_strobe;
      hold_ff      <= nxt_hold;
      done_ff      <= (nxt_pending == 3'h0);
      bufbits_ff   <= i_instr_bits;
      selbits_n_ff <= ~i_instr_bits[8:3];
    end
  end

  assign o_cmd_pulse           = cmd_ff;
  assign o_buffered_instr_bits = bufbits_ff;
  assign o_sel_bits_n          = selbits_n_ff;
  assign o_bus_strobe          = strobe_ff;
  assign o_timing_hold         = hold_ff;
  assign o_done                = done_ff;

  ////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!rst_n);

  sequence restart_delay_ends;
    state_ff == iosq_pkg::ST_RESTART_DELAY && tmr_last;
  endsequence

  sequence final_strobe;
    o_bus_strobe[*2] ##1 !o_timing_hold;
  endsequence

  cmd_one_hot_a: assert property ($onehot0(o_cmd_pulse))
    else $error("more than one command pulse active");

  cmd_order_a: assert property (
    (o_cmd_pulse.w2 || o_cmd_pulse.w4) |-> !pending_ff[0])
    else $error("higher weight pulse before weight one");

  cmd_gated_a: assert property (
    o_cmd_pulse != 3'h0 |-> window_ff && (o_cmd_pulse & ~pending_ff) == 3'h0)
    else $error("command pulse without window or flag");

  flag_set_a: assert property (
    i_time_pulse.two && !i_time_pulse.one && !stb_end
    |=> pending_ff == ($past(pending_ff) | $past(instr_low)))
    else $error("pending flags not set at time pulse two");

  flag_clear_a: assert property (
    i_time_pulse.one && !stb_end |=> pending_ff == 3'h0)
    else $error("pending flags not cleared at time pulse one");

  done_rise_a: assert property (
    $rose(o_done) && busy |-> $fell(window_ff))
    else $error("done rose outside the end of a pulse");

  hold_cause_a: assert property (
    $rose(o_timing_hold)
    |-> $past(i_io_instruction && !i_internal_io && !o_done))
    else $error("timing hold without external transfer");

  seq_start_a: assert property (
    state_ff == iosq_pkg::ST_IDLE && hold_ff && i_time_pulse.three
    |=> state_ff == iosq_pkg::ST_SEP ##2 state_ff == iosq_pkg::ST_SEP)
    else $error("sequence did not start at time pulse three");

  window_end_a: assert property (
    $fell(window_ff) |-> $past(o_bus_strobe) && !o_bus_strobe)
    else $error("window did not close with the strobe");

  pulse_strobe_a: assert property (
    $fell(o_cmd_pulse != 3'h0) |-> $past(o_bus_strobe, 2))
    else $error("command pulse ended without a bus strobe");

  no_width_a: assert property (
    state_ff == iosq_pkg::ST_WIDTH |-> !o_done)
    else $error("width interval started after done");

  final_strobe_a: assert property (restart_delay_ends |=> final_strobe)
    else $error("final strobe or hold release missing");

  guard_wait_a: assert property (
    $rose(state_ff == iosq_pkg::ST_RESTART_DELAY)
    |-> $past(state_ff == iosq_pkg::ST_GUARD, 4))
    else $error("restart delay began before the guard ran out");

  restart_delay_len_a: assert property (
    $rose(state_ff == iosq_pkg::ST_RESTART_DELAY)
    |-> (state_ff == iosq_pkg::ST_RESTART_DELAY)[*6] ##1 o_bus_strobe)
    else $error("restart delay is not 275 ns rounded up");

endmodule

// ===== iosq_cpu_model.sv
/* processor side of the sequencer: instruction word, pause level, time
   pulses one, two, three. assumes the hold output stalls it after tp3. */
`timescale 1ns/1ps

module iosq_cpu_model (
  input  wire logic          i_clk,
  input  wire logic          i_timing_hold,
  output logic [11:0]        o_instr_bits,
  output logic               o_io_instruction,
  output logic               o_internal_io,
  output iosq_pkg::iosq_tp_t o_time_pulse
);
  initial begin
    o_instr_bits = 12'h000;
    o_io_instruction = 1'b0;
    o_internal_io = 1'b0;
    o_time_pulse = 3'h0;
  end

  ////////////////////////////////////////////////////////////////////////
  // k = 1, 2 or 3; one clock wide, then an idle cycle follows
  task automatic pulse(input int k);
    @(posedge i_clk);
    o_time_pulse <= iosq_pkg::iosq_tp_t'(3'h1 << (3 - k));
    @(posedge i_clk);
    o_time_pulse <= 3'h0;
  endtask

  task automatic run(input logic [11:0] w, input logic internal);
    int n;
    @(posedge i_clk);
    o_instr_bits <= w;
    o_io_instruction <= 1'b1;
    o_internal_io <= internal;
    pulse(1);
    pulse(2);
    repeat (3) @(posedge i_clk);
    pulse(3);
    n = 0;
    // timing stays frozen in state three while the hold is up
    while (i_timing_hold === 1'b1 && n < 4000) begin
      @(posedge i_clk);
      n++;
    end
    @(posedge i_clk);
    o_io_instruction <= 1'b0;
    o_internal_io <= 1'b0;
    // bits released: show the inverse so a stale copy cannot match
    o_instr_bits <= ~w;
  endtask
endmodule

// ===== io_pulse_sequencer_tb.sv
/* testbench of the i/o pulse sequencer: wishbone tasks, processor runs,
   pulse timing monitor. assumes iosq_cpu_model drives the processor side. */
`timescale 1ns/1ps
`include "iosq_map.svh"
`define CHK(what, exp, got) begin checked++; if ((got) !== (exp)) begin \
  fail_count++; $display("BAD %s expected %0h seen %0h", what, exp, got); \
  end end

module io_pulse_sequencer_tb;
  logic                   i_clk;
  logic                   i_nrst;
  iosq_pkg::iosq_wb_req_t wb_req;
  logic                   ack;
  logic [31:0]            wb_dat;
  logic [11:0]            instr;
  logic                   io_instr;
  logic                   internal_io;
  iosq_pkg::iosq_tp_t     tp;
  iosq_pkg::iosq_cmd_t    cmd;
  logic [11:0]            bbits;
  logic [5:0]             sel_n;
  logic                   strobe;
  logic                   hold;
  logic                   done;
  int checked = 0, fail_count = 0, cyc_n = 0, t3 = 0, rise = 0, fall = 0;
  int stb_at = 0, n_cmd = 0, n_stb = 0;
  logic [2:0]             exp_s = 3'h1, exp_w = 3'h1, p_cmd = 3'h0;
  logic [11:0]            cur_word = 12'h000;
  logic [8:0]             ord = 9'h000;
  logic                   want_hold = 1'b0, p_stb = 1'b0, p_hold = 1'b0;
  logic [31:0]            rd;

  iosq_top iosq_top_inst (.i_clk(i_clk), .i_nrst(i_nrst), .i_wb_req(wb_req),
    .o_wb_ack(ack), .o_wb_dat(wb_dat), .i_instr_bits(instr),
    .i_io_instruction(io_instr), .i_internal_io(internal_io),
    .i_time_pulse(tp), .o_cmd_pulse(cmd), .o_buffered_instr_bits(bbits),
    .o_sel_bits_n(sel_n), .o_bus_strobe(strobe), .o_timing_hold(hold),
    .o_done(done));
  iosq_cpu_model iosq_cpu_model_inst (.i_clk(i_clk), .i_timing_hold(hold),
    .o_instr_bits(instr), .o_io_instruction(io_instr),
    .o_internal_io(internal_io), .o_time_pulse(tp));

  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic wb_xfer(input logic we, input logic [3:0] adr,
                         input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    @(posedge i_clk);
    wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hf, dat: wd};
    n = 0;
    do begin
      @(posedge i_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (n >= 50) fail_count++;
    rdat = wb_dat;
    wb_req <= '0;
    @(posedge i_clk);
  endtask

  task automatic run(input logic [2:0] s, w, input logic [11:0] word,
                     input logic internal);
    logic [8:0] oe;
    int ne;
    wb_xfer(1'b1, `IOSQ_REG_CTRL, {25'h0, w, 1'b0, s}, rd);
    exp_s = s;
    exp_w = w;
    cur_word = word;
    want_hold = !internal;
    n_cmd = 0;
    n_stb = 0;
    ord = 9'h000;
    oe = 9'h000;
    ne = 0;
    for (int j = 11; j >= 9; j--)
      if (word[j] && !internal) begin
        oe = {oe[5:0], 3'h1 << (11 - j)};
        ne++;
      end
    iosq_cpu_model_inst.run(word, internal);
    repeat (3) @(posedge i_clk);
    `CHK("pulse order", oe, ord)
    `CHK("pulse count", ne, n_cmd)
    `CHK("strobe count", ne + (internal ? 0 : 1), n_stb)
    if (!internal) `CHK("idle done hold", 2'h1, {hold, done})
  endtask

  ////////////////////////////////////////////////////////////////////////
  // timing monitor: every figure is counted in clocks from sampled edges
  always @(posedge i_clk) begin
    cyc_n++;
    if (tp.three) begin
      t3 = cyc_n;
      `CHK("buffered bits", cur_word, bbits)
      `CHK("select bits", ~cur_word[8:3], sel_n)
      `CHK("hold at tp3", want_hold, hold)
      if (want_hold) `CHK("done at tp3", 1'b0, done)
    end
    if (strobe && !p_stb) begin
      n_stb++;
      stb_at = cyc_n;
    end
    if (cmd != 3'h0 && p_cmd == 3'h0) begin
      ord = {ord[5:0], cmd};
      n_cmd++;
      rise = cyc_n;
      `CHK("decode bits", cur_word, bbits)
      if (n_cmd == 1) `CHK("first lead", 3 + 4 * exp_s, cyc_n - t3)
      else `CHK("pulse spacing", 2 + 4 * exp_s, cyc_n - fall)
    end
    if (cmd == 3'h0 && p_cmd != 3'h0) begin
      fall = cyc_n;
      `CHK("pulse width", 2 + 12 * exp_w, cyc_n - rise)
      `CHK("strobe at end", cyc_n - 2, stb_at)
    end
    if (!hold && p_hold) begin
      `CHK("release delay", 12, cyc_n - fall)
      `CHK("final strobe", 2, cyc_n - stb_at)
    end
    p_cmd = cmd;
    p_stb = strobe;
    p_hold = hold;
  end

  // longest run is near 115 clocks; this leaves a wide margin
  initial begin
    repeat (20000) @(posedge i_clk);
    fail_count++;
    print_verdict;
  end

  initial begin
    i_nrst = 1'b0;
    wb_req = '0;
    repeat (6) @(posedge i_clk);
    `CHK("reset outputs", 6'h01, {cmd, strobe, hold, done})
    `CHK("reset select", 6'h3f, sel_n)
    i_nrst <= 1'b1;
    repeat (4) @(posedge i_clk);
    wb_xfer(1'b1, `IOSQ_REG_CTRL, 32'h0, rd);
    wb_xfer(1'b0, `IOSQ_REG_CTRL, 32'h0, rd);
    `CHK("ctrl floor", 7'h11, rd[6:0])
    wb_xfer(1'b1, `IOSQ_REG_CTRL, 32'h77, rd);
    wb_xfer(1'b0, `IOSQ_REG_CTRL, 32'h0, rd);
    `CHK("ctrl ceiling", 7'h55, rd[6:0])
    wb_xfer(1'b0, 4'h8, 32'h0, rd);
    `CHK("unmapped read", 32'h0, rd)
    run(3'h1, 3'h1, 12'he38, 1'b0);
    run(3'h5, 3'h5, 12'h255, 1'b0);
    run(3'h2, 3'h3, 12'h5c0, 1'b0);
    run(3'h3, 3'h1, 12'ha00, 1'b0);
    run(3'h1, 3'h1, 12'h800, 1'b1);
    wb_xfer(1'b0, `IOSQ_REG_STAT, 32'h0, rd);
    `CHK("pending kept", 4'h1, rd[3:0])
    iosq_cpu_model_inst.pulse(1);
    wb_xfer(1'b0, `IOSQ_REG_STAT, 32'h0, rd);
    `CHK("pending cleared", 4'h8, rd[3:0])
    print_verdict;
  end
endmodule
